// ### logic/chs_pkg.sv
package chs_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam int          ADR_W        = 8;
	localparam logic [7:0]  OFS_CTRL     = 8'h00;
	localparam logic [7:0]  OFS_INSTR    = 8'h04;
	localparam logic [7:0]  OFS_STATUS   = 8'h08;
	localparam logic [7:0]  OFS_IRQ_STAT = 8'h0c;
	localparam logic [7:0]  OFS_IRQ_MASK = 8'h10;
	localparam logic [7:0]  OFS_FAULT    = 8'h14;
	localparam logic [7:0]  OFS_GPR_BASE = 8'h40;
	localparam logic [7:0]  GPR_SPAN_MSK = 8'he0;
	localparam int          GPR_IDX_LSB  = 2;
	localparam int          NUM_GPR      = 8;
	localparam logic [31:0] RD_UNMAPPED  = 32'h00000000;

	// ------------------------------------------------------------
	// Opcodes of the four compact encodings
	// ------------------------------------------------------------
	localparam logic [4:0] OP5_STORE_IMM = 5'h10;
	localparam logic [6:0] OP7_STORE_REG = 7'h29;
	localparam logic [6:0] OP7_SUB_IMM3  = 7'h0f;
	localparam logic [4:0] OP5_SUB_IMM8  = 5'h07;
	localparam int         HALF_SHIFT    = 1;

	// Instruction formats
	typedef struct packed {
		logic [4:0] op;
		logic [4:0] imm5;
		logic [2:0] baseReg;
		logic [2:0] srcReg;
	} chs_fmt_imm5_t;

	typedef struct packed {
		logic [6:0] op;
		logic [2:0] mid;
		logic [2:0] baseReg;
		logic [2:0] dstReg;
	} chs_fmt_reg3_t;

	typedef struct packed {
		logic [4:0] op;
		logic [2:0] dstReg;
		logic [7:0] imm8;
	} chs_fmt_imm8_t;

	// ------------------------------------------------------------
	// Control, flags, events
	// ------------------------------------------------------------
	typedef struct packed {
		logic beMixed;
		logic wordInvBe;
		logic legacyCheck;
		logic legacyCore;
		logic unalignedSupport;
		logic alignCheck;
	} chs_ctrl_t;
	localparam int        CTRL_W   = $bits(chs_ctrl_t);
	localparam chs_ctrl_t CTRL_RST = '0;

	typedef struct packed {
		logic n;
		logic z;
		logic c;
		logic v;
	} chs_flags_t;

	typedef struct packed {
		logic illegal;
		logic alignFault;
		logic dataAbort;
		logic done;
	} chs_irq_t;
	localparam int IRQ_W = $bits(chs_irq_t);

	typedef enum logic [1:0] {
		FAULT_NONE     = 2'h0,
		FAULT_ALIGN    = 2'h1,
		FAULT_EXTERNAL = 2'h2
	} chs_fault_t;

	typedef struct packed {
		logic       busy;
		chs_flags_t flags;
		chs_fault_t fault;
	} chs_status_t;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b001,
		ST_EXEC    = 3'b010,
		ST_MEMWAIT = 3'b100
	} chs_state_t;

endpackage : chs_pkg

// ### logic/chs_sub_unit.sv
module chs_sub_unit (
	// Operands
	input  wire logic [31:0]       minuend,
	input  wire logic [31:0]       subtrahend,
	// Result
	output logic [31:0]            result,
	output chs_pkg::chs_flags_t    flags
);

	logic [32:0] diff;

	always_comb begin
		diff         = {1'b0, minuend} - {1'b0, subtrahend};
		result       = diff[31:0];
		flags.n      = diff[31];
		flags.z      = (diff[31:0] == 32'h00000000);
		flags.c      = ~diff[32];
		flags.v      = (minuend[31] ^ subtrahend[31]) &
		               (minuend[31] ^ diff[31]);
	end

endmodule : chs_sub_unit

// ### logic/chs_addr_unit.sv
module chs_addr_unit (
	// Address operands
	input  wire logic [31:0]       base,
	input  wire logic [31:0]       offset,
	input  chs_pkg::chs_ctrl_t     ctrl,
	// Results
	output logic [31:0]            effAddr,
	output logic [31:0]            busAddr,
	output logic                   alignAbort
);

	localparam logic [31:0] WINV_HALF_FLIP = 32'h00000002;

	always_comb begin
		effAddr    = base + offset;
		// Pre-v6 check optional, later governed by alignment bit
		alignAbort = effAddr[0] & (ctrl.legacyCore ?
		             ctrl.legacyCheck : ctrl.alignCheck);
		// Legacy word-invariant big endian swaps halfword lanes
		busAddr    = (ctrl.legacyCore & ctrl.wordInvBe) ?
		             (effAddr ^ WINV_HALF_FLIP) : effAddr;
	end

endmodule : chs_addr_unit

// ### logic/chs_decode_exec.sv
// Functional notes
// - Immediate halfword store writes source low half
// - Immediate store address: base plus doubled offset
// - Zero offset leaves base address unchanged
// - Register store address: base plus offset register
// - Store aborts raise data abort; alignment aborts also raise alignFault
// - Pre-v6: optional abort when address bit0 set
// - Alignment bit set: unaligned store alignment-faults
// - Alignment bit clear: unaligned store performed
// - Byte-invariant big endian; legacy word-invariant optional
// - Subtract 3-bit constant into destination register
// - 3-bit subtract: carry not borrow, signed overflow
// - Negative from bit 31, zero when result zero
// - Subtract 8-bit constant in place
// - 8-bit subtract: carry not borrow, signed overflow
module chs_decode_exec (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        ce,
	// Wishbone slave
	input  wire logic        wbCycI,
	input  wire logic        wbStbI,
	input  wire logic        wbWeI,
	input  wire logic [7:0]  wbAdrI,
	input  wire logic [3:0]  wbSelI,
	input  wire logic [31:0] wbDatI,
	output logic      [31:0] wbDatO,
	output logic             wbAckO,
	// Memory store port
	output logic             memReqO,
	output logic      [31:0] memAddrO,
	output logic      [15:0] memDataO,
	input  wire logic        memAckI,
	input  wire logic        memErrI,
	// Interrupt
	output logic             irqO
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	chs_pkg::chs_ctrl_t   ctrl;
	chs_pkg::chs_flags_t  flags;
	chs_pkg::chs_fault_t  fault;
	chs_pkg::chs_irq_t    irqStat;
	chs_pkg::chs_irq_t    irqMask;
	chs_pkg::chs_state_t  state;
	logic [15:0]          instr;
	logic [31:0]          faultAddr;
	logic [31:0]          gpr [chs_pkg::NUM_GPR];

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic        busReq;
	logic        busWr;
	logic [31:0] wMask;
	logic [31:0] wData;
	logic        hitGpr;
	logic [2:0]  gprIdx;

	assign busReq = wbCycI & wbStbI & ~wbAckO;
	assign busWr  = busReq & wbWeI;
	assign wMask  = {{8{wbSelI[3]}}, {8{wbSelI[2]}},
	                 {8{wbSelI[1]}}, {8{wbSelI[0]}}};
	assign wData  = wbDatI & wMask;
	assign hitGpr = (wbAdrI & chs_pkg::GPR_SPAN_MSK) ==
	                chs_pkg::OFS_GPR_BASE;
	assign gprIdx = wbAdrI[chs_pkg::GPR_IDX_LSB +: 3];

	// ------------------------------------------------------------
	// Instruction decode
	// ------------------------------------------------------------
	chs_pkg::chs_fmt_imm5_t fImm5;
	chs_pkg::chs_fmt_reg3_t fReg3;
	chs_pkg::chs_fmt_imm8_t fImm8;
	logic        isStoreImm;
	logic        isStoreReg;
	logic        isSub3;
	logic        isSub8;
	logic        isStore;
	logic [2:0]  baseIdx;
	logic [2:0]  srcIdx;
	logic [2:0]  dstIdx;
	logic [31:0] storeOffset;
	logic [31:0] subA;
	logic [31:0] subB;

	assign fImm5 = instr;
	assign fReg3 = instr;
	assign fImm8 = instr;

	always_comb begin
		isStoreImm  = fImm5.op == chs_pkg::OP5_STORE_IMM;
		isStoreReg  = fReg3.op == chs_pkg::OP7_STORE_REG;
		isSub3      = fReg3.op == chs_pkg::OP7_SUB_IMM3;
		isSub8      = fImm8.op == chs_pkg::OP5_SUB_IMM8;
		isStore     = isStoreImm | isStoreReg;
		baseIdx     = fReg3.baseReg;
		srcIdx      = fReg3.dstReg;
		dstIdx      = fReg3.dstReg;
		storeOffset = gpr[fReg3.mid];
		subA        = gpr[fReg3.baseReg];
		subB        = 32'(fReg3.mid);
		if (isStoreImm) begin
			baseIdx     = fImm5.baseReg;
			srcIdx      = fImm5.srcReg;
			storeOffset = 32'(fImm5.imm5) << chs_pkg::HALF_SHIFT;
		end
		if (isSub8) begin
			dstIdx = fImm8.dstReg;
			subA   = gpr[fImm8.dstReg];
			subB   = 32'(fImm8.imm8);
		end
	end

	// ------------------------------------------------------------
	// Datapath units
	// ------------------------------------------------------------
	logic [31:0]         subResult;
	chs_pkg::chs_flags_t subFlags;
	logic [31:0]         effAddr;
	logic [31:0]         busAddr;
	logic                alignAbort;
	logic [15:0]         storeHalf;

	chs_sub_unit u_sub (
		.minuend    (subA),
		.subtrahend (subB),
		.result     (subResult),
		.flags      (subFlags)
	);

	chs_addr_unit u_addr (
		.base       (gpr[baseIdx]),
		.offset     (storeOffset),
		.ctrl       (ctrl),
		.effAddr    (effAddr),
		.busAddr    (busAddr),
		.alignAbort (alignAbort)
	);

	// Byte-invariant big endian swaps the two bytes of the half
	always_comb begin
		storeHalf = gpr[srcIdx][15:0];
		if (ctrl.beMixed & ~ctrl.legacyCore)
			storeHalf = {storeHalf[7:0], storeHalf[15:8]};
	end

	// ------------------------------------------------------------
	// Events
	// ------------------------------------------------------------
	logic inExec;
	logic evIssue;
	logic evAlign;
	logic evExtAbort;
	logic evMemDone;
	logic evSubDone;
	logic evIllegal;
	logic evDone;

	assign inExec     = state == chs_pkg::ST_EXEC;
	assign evIssue    = busWr & (wbAdrI == chs_pkg::OFS_INSTR) &
	                    (state == chs_pkg::ST_IDLE);
	assign evAlign    = inExec & isStore & alignAbort;
	assign evSubDone  = inExec & (isSub3 | isSub8);
	assign evIllegal  = inExec & ~isStore & ~isSub3 & ~isSub8;
	assign evExtAbort = (state == chs_pkg::ST_MEMWAIT) & memErrI;
	assign evMemDone  = (state == chs_pkg::ST_MEMWAIT) & memAckI &
	                    ~memErrI;
	assign evDone     = evSubDone | evMemDone;

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!resetn) begin
			state <= chs_pkg::ST_IDLE;
		end else if (ce) begin
			unique case (state)
				chs_pkg::ST_IDLE: begin
					if (evIssue)
						state <= chs_pkg::ST_EXEC;
				end
				chs_pkg::ST_EXEC: begin
					if (isStore && !alignAbort)
						state <= chs_pkg::ST_MEMWAIT;
					else
						state <= chs_pkg::ST_IDLE;
				end
				chs_pkg::ST_MEMWAIT: begin
					if (memAckI || memErrI)
						state <= chs_pkg::ST_IDLE;
				end
				default: state <= chs_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			instr <= 16'h0000;
		end else if (ce && evIssue) begin
			instr <= wbDatI[15:0];
		end
	end

	// ------------------------------------------------------------
	// Memory request
	// ------------------------------------------------------------
	// Misaligned without a check is performed as a plain half store
	always_ff @(posedge clock) begin
		if (!resetn) begin
			memReqO  <= 1'b0;
			memAddrO <= 32'h00000000;
			memDataO <= 16'h0000;
		end else if (ce) begin
			if (inExec && isStore && !alignAbort) begin
				memReqO  <= 1'b1;
				memAddrO <= busAddr;
				memDataO <= storeHalf;
			end else if (memAckI || memErrI) begin
				memReqO  <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	// Stores never write back, so an abort leaves base and offset
	always_ff @(posedge clock) begin
		if (!resetn) begin
			for (int i = 0; i < chs_pkg::NUM_GPR; i++)
				gpr[i] <= 32'h00000000;
		end else if (ce) begin
			if (evSubDone)
				gpr[dstIdx] <= subResult;
			else if (busWr && hitGpr && state == chs_pkg::ST_IDLE)
				gpr[gprIdx] <= (gpr[gprIdx] & ~wMask) | wData;
		end
	end

	// ------------------------------------------------------------
	// Flags and fault record
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!resetn) begin
			flags <= '0;
		end else if (ce && evSubDone) begin
			flags <= subFlags;
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			fault     <= chs_pkg::FAULT_NONE;
			faultAddr <= 32'h00000000;
		end else if (ce) begin
			if (evAlign) begin
				fault     <= chs_pkg::FAULT_ALIGN;
				faultAddr <= effAddr;
			end else if (evExtAbort) begin
				fault     <= chs_pkg::FAULT_EXTERNAL;
				faultAddr <= memAddrO;
			end else if (evIssue) begin
				fault     <= chs_pkg::FAULT_NONE;
			end
		end
	end

	// ------------------------------------------------------------
	// Control and interrupt registers
	// ------------------------------------------------------------
	chs_pkg::chs_irq_t irqSet;
	chs_pkg::chs_irq_t irqClr;

	always_comb begin
		irqSet.done       = evDone;
		irqSet.dataAbort  = evExtAbort | evAlign;
		irqSet.alignFault = evAlign;
		irqSet.illegal    = evIllegal;
		irqClr            = '0;
		if (busWr && wbAdrI == chs_pkg::OFS_IRQ_STAT)
			irqClr = wData[chs_pkg::IRQ_W-1:0];
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			ctrl <= chs_pkg::CTRL_RST;
		end else if (ce && busWr && wbAdrI == chs_pkg::OFS_CTRL) begin
			ctrl <= (ctrl & ~wMask[chs_pkg::CTRL_W-1:0]) |
			        wData[chs_pkg::CTRL_W-1:0];
		end
	end

	// Set wins over a simultaneous clear
	always_ff @(posedge clock) begin
		if (!resetn) begin
			irqStat <= '0;
			irqMask <= '0;
		end else if (ce) begin
			irqStat <= (irqStat & ~irqClr) | irqSet;
			if (busWr && wbAdrI == chs_pkg::OFS_IRQ_MASK)
				irqMask <= (irqMask & ~wMask[chs_pkg::IRQ_W-1:0]) |
				           wData[chs_pkg::IRQ_W-1:0];
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn)
			irqO <= 1'b0;
		else if (ce)
			irqO <= |(((irqStat & ~irqClr) | irqSet) & irqMask);
	end

	// ------------------------------------------------------------
	// Bus answer
	// ------------------------------------------------------------
	chs_pkg::chs_status_t status;
	logic [31:0]          rdData;

	always_comb begin
		status.busy  = state != chs_pkg::ST_IDLE;
		status.flags = flags;
		status.fault = fault;
		rdData       = chs_pkg::RD_UNMAPPED;
		if (hitGpr)
			rdData = gpr[gprIdx];
		else begin
			unique case (wbAdrI)
				chs_pkg::OFS_CTRL:     rdData = 32'(ctrl);
				chs_pkg::OFS_INSTR:    rdData = 32'(instr);
				chs_pkg::OFS_STATUS:   rdData = 32'(status);
				chs_pkg::OFS_IRQ_STAT: rdData = 32'(irqStat);
				chs_pkg::OFS_IRQ_MASK: rdData = 32'(irqMask);
				chs_pkg::OFS_FAULT:    rdData = faultAddr;
				default:               rdData = chs_pkg::RD_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			wbAckO <= 1'b0;
			wbDatO <= 32'h00000000;
		end else if (ce) begin
			wbAckO <= busReq;
			if (busReq && !wbWeI)
				wbDatO <= rdData;
		end
	end

endmodule : chs_decode_exec

// ### dv/chs_decode_exec_sva.sv
module chs_decode_exec_sva (
	// Clock and reset
	input wire logic        clock,
	input wire logic        resetn,
	input wire logic        ce,
	// Register bus
	input wire logic        wbCycI,
	input wire logic        wbStbI,
	input wire logic        wbWeI,
	input wire logic [7:0]  wbAdrI,
	input wire logic [3:0]  wbSelI,
	input wire logic [31:0] wbDatI,
	input wire logic        wbAckO,
	// Store port and interrupt
	input wire logic        memReqO,
	input wire logic [31:0] memAddrO,
	input wire logic [15:0] memDataO,
	input wire logic        memAckI,
	input wire logic        memErrI,
	input wire logic        irqO
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       take;
	logic       instrTk;
	logic [5:0] ctrl;
	logic [3:0] mask;

	assign take    = wbCycI && wbStbI && !wbAckO && ce;
	assign instrTk = take && wbWeI && wbAdrI == chs_pkg::OFS_INSTR;

	// Shadow of control and mask
	always_ff @(posedge clock) begin
		if (!resetn) begin
			ctrl <= '0;
			mask <= '0;
		end else if (take && wbWeI && wbSelI[0]) begin
			if (wbAdrI == chs_pkg::OFS_CTRL)
				ctrl <= wbDatI[5:0];
			if (wbAdrI == chs_pkg::OFS_IRQ_MASK)
				mask <= wbDatI[3:0];
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	sequence s_take;
		take;
	endsequence
	sequence s_done;
		memReqO && (memAckI || memErrI) && ce;
	endsequence

	ack_pulse_a: assert property (wbAckO && ce |=> !wbAckO)
		else $error("ack longer than one cycle");
	ack_answer_a: assert property (s_take |=> wbAckO)
		else $error("request not acked next cycle");
	ack_cause_a: assert property ($rose(wbAckO) |-> $past(wbStbI))
		else $error("ack without request");
	store_launch_a: assert property ($rose(memReqO) |-> $past(instrTk, 2))
		else $error("store request not two cycles after issue");
	store_hold_a: assert property (memReqO && !memAckI && !memErrI && ce
		|=> memReqO && $stable(memAddrO) && $stable(memDataO))
		else $error("store request changed before answer");
	store_release_a: assert property (s_done |-> ##[1:2] !memReqO)
		else $error("store request held after answer");
	align_block_a: assert property (memReqO |-> !(ctrl[0] && !ctrl[2] && memAddrO[0]))
		else $error("unaligned store sent with check on");
	legacy_block_a: assert property (memReqO |-> !(ctrl[2] && ctrl[3] && memAddrO[0]))
		else $error("unaligned legacy store sent with check on");
	irq_mask_a: assert property (mask == 4'h0 && $past(mask) == 4'h0 |-> !irqO)
		else $error("interrupt with all sources masked");
endmodule : chs_decode_exec_sva

bind chs_decode_exec chs_decode_exec_sva chs_decode_exec_sva_inst (
	.clock(clock), .resetn(resetn), .ce(ce), .wbCycI(wbCycI),
	.wbStbI(wbStbI), .wbWeI(wbWeI), .wbAdrI(wbAdrI), .wbSelI(wbSelI),
	.wbDatI(wbDatI), .wbAckO(wbAckO), .memReqO(memReqO),
	.memAddrO(memAddrO), .memDataO(memDataO), .memAckI(memAckI),
	.memErrI(memErrI), .irqO(irqO));

// ### dv/chs_mem_model.sv
module chs_mem_model (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        resetn,
	// Behaviour
	input  wire logic [3:0]  delay,
	input  wire logic        errMode,
	// Store port
	input  wire logic        memReqO,
	input  wire logic [31:0] memAddrO,
	input  wire logic [15:0] memDataO,
	output logic             memAckI,
	output logic             memErrI,
	// Record of writes
	output logic      [31:0] lastAddr,
	output logic      [15:0] lastData,
	output logic      [7:0]  nWrites
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt;
	logic       held;

	always_ff @(posedge clock) begin
		memAckI <= 1'b0;
		memErrI <= 1'b0;
		if (!resetn) begin
			cnt     <= '0;
			held    <= 1'b0;
			nWrites <= '0;
		end else if (!memReqO) begin
			cnt  <= '0;
			held <= 1'b0;
		end else if (!held) begin
			if (cnt == delay) begin
				held <= 1'b1;
				if (errMode)
					memErrI <= 1'b1;
				else begin
					memAckI  <= 1'b1;
					lastAddr <= memAddrO;
					lastData <= memDataO;
					nWrites  <= nWrites + 8'h01;
				end
			end else
				cnt <= cnt + 4'h1;
		end
	end
endmodule : chs_mem_model

// ### dv/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock = 1'b0;
	logic        resetn, ce, wbCycI, wbStbI, wbWeI;
	logic [7:0]  wbAdrI;
	logic [3:0]  wbSelI;
	logic [31:0] wbDatI, wbDatO, memAddrO, lastAddr, q;
	logic        wbAckO, memReqO, memAckI, memErrI, irqO, errMode;
	logic [15:0] memDataO, lastData;
	logic [7:0]  nWrites;
	logic [3:0]  delay;
	int          err_total, n_compared;
	logic [31:0] va[3] = '{32'h80000000, 32'h000000ff, 32'h0};
	logic [7:0]  im[3] = '{8'h01, 8'hff, 8'hff};
	logic [31:0] ex[3] = '{32'h7fffffff, 32'h0, 32'hffffff01};
	logic [31:0] fl[3] = '{32'h0c, 32'h18, 32'h20};
	logic [31:0] cv[2] = '{32'h01, 32'h0c};

	chs_decode_exec chs_decode_exec_inst (.clock(clock), .resetn(resetn),
		.ce(ce), .wbCycI(wbCycI), .wbStbI(wbStbI), .wbWeI(wbWeI),
		.wbAdrI(wbAdrI), .wbSelI(wbSelI), .wbDatI(wbDatI),
		.wbDatO(wbDatO), .wbAckO(wbAckO), .memReqO(memReqO),
		.memAddrO(memAddrO), .memDataO(memDataO), .memAckI(memAckI),
		.memErrI(memErrI), .irqO(irqO));
	chs_mem_model chs_mem_model_inst (.clock(clock), .resetn(resetn),
		.delay(delay), .errMode(errMode), .memReqO(memReqO),
		.memAddrO(memAddrO), .memDataO(memDataO), .memAckI(memAckI),
		.memErrI(memErrI), .lastAddr(lastAddr), .lastData(lastData),
		.nWrites(nWrites));

	always #2 clock = ~clock;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: %h, expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s, output logic [31:0] r);
		int n;
		n = 0;
		wbCycI <= 1'b1;
		wbStbI <= 1'b1;
		wbWeI  <= w;
		wbAdrI <= a;
		wbDatI <= d;
		wbSelI <= s;
		do begin
			@(posedge clock);
			n++;
		end while (wbAckO !== 1'b1 && n < 50);
		if (n >= 50)
			err_total++;
		r = wbDatO;
		wbCycI <= 1'b0;
		wbStbI <= 1'b0;
		@(posedge clock);
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		wb(1'b1, a, d, 4'hf, r);
	endtask : wr

	task automatic rdm(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] r;
		wb(1'b0, a, 32'h0, 4'hf, r);
		chk(r & m, e);
	endtask : rdm

	function automatic logic [7:0] gpr(input int i);
		return chs_pkg::OFS_GPR_BASE + 8'(i * 4);
	endfunction : gpr

	// Issue one instruction and poll until idle
	task automatic run(input logic [15:0] op);
		logic [31:0] r;
		int n;
		wr(chs_pkg::OFS_INSTR, {16'h0, op});
		n = 0;
		do begin
			wb(1'b0, chs_pkg::OFS_STATUS, 32'h0, 4'hf, r);
			n++;
		end while (r[6] !== 1'b0 && n < 50);
		if (n >= 50)
			err_total++;
	endtask : run

	task automatic results();
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results

	initial begin
		repeat (20000) @(posedge clock);
		err_total++;
		results();
	end

	initial begin
		{resetn, wbCycI, wbStbI, wbWeI, errMode} = '0;
		{wbAdrI, wbSelI, wbDatI, delay} = '0;
		ce = 1'b1;
		repeat (4) @(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
		// --------------------------------------------------
		// Registers
		// --------------------------------------------------
		wr(gpr(0), 32'h1234beef);
		wr(gpr(1), 32'h5);
		wr(gpr(4), 32'h100);
		wr(gpr(5), 32'h21);
		wb(1'b1, gpr(6), 32'hffffffff, 4'h3, q);
		rdm(gpr(6), 32'hffffffff, 32'h0000ffff);
		rdm(8'h30, 32'hffffffff, chs_pkg::RD_UNMAPPED);
		$display("test registers done");
		// --------------------------------------------------
		// Subtracts and interrupt
		// --------------------------------------------------
		run({chs_pkg::OP7_SUB_IMM3, 3'd7, 3'd1, 3'd2});
		rdm(gpr(2), 32'hffffffff, 32'hfffffffe);
		rdm(chs_pkg::OFS_STATUS, 32'h7f, 32'h20);
		chk(32'(irqO), 32'h0);
		wr(chs_pkg::OFS_IRQ_MASK, 32'h1);
		repeat (2) @(posedge clock);
		chk(32'(irqO), 32'h1);
		wr(chs_pkg::OFS_IRQ_STAT, 32'hf);
		repeat (2) @(posedge clock);
		chk(32'(irqO), 32'h0);
		wr(chs_pkg::OFS_IRQ_MASK, 32'h0);
		for (int i = 0; i < 3; i++) begin
			wr(gpr(3), va[i]);
			run({chs_pkg::OP5_SUB_IMM8, 3'd3, im[i]});
			rdm(gpr(3), 32'hffffffff, ex[i]);
			rdm(chs_pkg::OFS_STATUS, 32'h7c, fl[i]);
			rdm(chs_pkg::OFS_IRQ_STAT, 32'he, 32'h0);
		end
		$display("test subtract done");
		// --------------------------------------------------
		// Stores
		// --------------------------------------------------
		run({chs_pkg::OP5_STORE_IMM, 5'd3, 3'd4, 3'd0});
		chk(lastAddr, 32'h106);
		chk(32'(lastData), 32'hbeef);
		run({chs_pkg::OP5_STORE_IMM, 5'd0, 3'd4, 3'd0});
		chk(lastAddr, 32'h100);
		wr(chs_pkg::OFS_CTRL, 32'h2);
		delay <= 4'd5;
		run({chs_pkg::OP7_STORE_REG, 3'd5, 3'd4, 3'd0});
		chk(lastAddr, 32'h121);
		chk(32'(nWrites), 32'h3);
		for (int i = 0; i < 2; i++) begin
			wr(chs_pkg::OFS_IRQ_STAT, 32'hf);
			wr(chs_pkg::OFS_CTRL, cv[i]);
			run({chs_pkg::OP7_STORE_REG, 3'd5, 3'd4, 3'd0});
			chk(32'(nWrites), 32'h3);
			rdm(chs_pkg::OFS_STATUS, 32'h3, 32'h1);
			rdm(chs_pkg::OFS_FAULT, 32'hffffffff, 32'h121);
			rdm(chs_pkg::OFS_IRQ_STAT, 32'he, 32'h6);
			rdm(gpr(5), 32'hffffffff, 32'h21);
		end
		wr(chs_pkg::OFS_CTRL, 32'h0);
		wr(chs_pkg::OFS_IRQ_STAT, 32'hf);
		errMode <= 1'b1;
		run({chs_pkg::OP5_STORE_IMM, 5'd3, 3'd4, 3'd0});
		chk(32'(nWrites), 32'h3);
		rdm(chs_pkg::OFS_STATUS, 32'h3, 32'h2);
		rdm(chs_pkg::OFS_FAULT, 32'hffffffff, 32'h106);
		rdm(chs_pkg::OFS_IRQ_STAT, 32'he, 32'h2);
		rdm(gpr(4), 32'hffffffff, 32'h100);
		// Byte-invariant swap, then legacy word-invariant lane flip
		errMode <= 1'b0;
		wr(chs_pkg::OFS_CTRL, 32'h20);
		run({chs_pkg::OP5_STORE_IMM, 5'd3, 3'd4, 3'd0});
		chk(lastAddr, 32'h106);
		chk(32'(lastData), 32'hefbe);
		wr(chs_pkg::OFS_CTRL, 32'h14);
		run({chs_pkg::OP5_STORE_IMM, 5'd3, 3'd4, 3'd0});
		chk(lastAddr, 32'h104);
		chk(32'(lastData), 32'hbeef);
		$display("test store done");
		results();
	end
endmodule : tb_top
